// File: blit_pkg.sv
// constants, register indices and field layout for the block-transfer pixel datapath
package blit_pkg;
  // ---------------------------------------------------------------
  // register word layout
  // ---------------------------------------------------------------
  localparam int          WORD_W      = 16;
  localparam int          IDX_W       = 4;
  localparam int          IDX_LO      = 12;
  localparam int          PITCH_W     = 12;
  localparam int          ROP_W       = 4;
  localparam int          ROP_LO      = 8;
  localparam int          COLOR_W     = 8;
  localparam int          MAP_W       = 4;
  localparam int          PAT_AXIS_W  = 3;
  localparam int          PAT_IDX_W   = 6;
  localparam int          ADDR_W      = 20;

  // ---------------------------------------------------------------
  // register indices (top four bits of each written word)
  // ---------------------------------------------------------------
  localparam logic [3:0]  IDX_ROW_PITCH   = 4'h8;
  localparam logic [3:0]  IDX_RASTER_OP   = 4'h9;
  localparam logic [3:0]  IDX_FOREGROUND  = 4'hA;
  localparam logic [3:0]  IDX_BACKGROUND  = 4'hB;
  localparam logic [3:0]  IDX_WRITE_MASK  = 4'hE;
  localparam logic [3:0]  IDX_DP_CONTROL  = 4'hF;

  // ---------------------------------------------------------------
  // datapath control word fields
  // ---------------------------------------------------------------
  localparam int          CTL_PLANAR    = 0;
  localparam int          CTL_SRC_LO    = 1;
  localparam int          CTL_PATTERN   = 3;
  localparam int          CTL_SRC_RECT  = 4;
  localparam int          CTL_DST_RECT  = 5;
  localparam int          CTL_W         = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] PITCH_RST   = 12'h000;
  localparam logic [3:0]  ROP_RST     = 4'h3;   // source copy
  localparam logic [7:0]  COLOR_RST   = 8'h00;
  localparam logic [7:0]  MASK_RST    = 8'hFF;  // all planes writable
  localparam logic [5:0]  CTL_RST     = 6'h30;  // packed, memory source, both rectangular
  localparam logic [3:0]  NIBBLE_ZERO = 4'h0;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  // source selection modes
  typedef enum logic [1:0] {
    SRC_MEMORY = 2'b00,
    SRC_MONO   = 2'b01,
    SRC_FIXED  = 2'b10
  } src_sel_t;
endpackage

// File: blit_rop_mask_datapath.sv
// block-transfer pixel datapath: registers, address stepping, pattern wrap, colour expansion, rop and masks
// Behaviour
// - index 1000 holds 12-bit row pitch
// - pitch added in position field units
// - pitch only steps rectangular regions
// - colours expand mono; foreground fills solid
// - planar mode uses colour bits 3:0
// - colours at 1010/1011, bits 11:8 reserved
// - map mask bit n enables map n
// - plane mask bit n enables plane n
// - mask at 1110; planar uses low four
// - rop code at 1001, bits 11:8
// - result bit is code bit by S,D
// - sixteen codes give all Boolean functions
// - bitwise logic only, never arithmetic
// - 8x8 pattern repeated across destination
// - mono 0 background, 1 foreground
// - pattern wraps right and down from anchor
// - fixed source fills with foreground colour
`timescale 1ns/1ps
module blit_rop_mask_datapath (
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  input  wire logic [blit_pkg::IDX_W-1:0]     reg_addr,
  input  wire logic [blit_pkg::WORD_W-1:0]    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [blit_pkg::WORD_W-1:0]    reg_rdata,
  input  wire logic                           addr_load,
  input  wire logic [blit_pkg::ADDR_W-1:0]    src_start,
  input  wire logic [blit_pkg::ADDR_W-1:0]    dst_start,
  input  wire logic [blit_pkg::PAT_IDX_W-1:0] pat_anchor,
  input  wire logic                           next_pixel,
  input  wire logic                           next_row,
  output logic      [blit_pkg::ADDR_W-1:0]    src_addr,
  output logic      [blit_pkg::ADDR_W-1:0]    dst_addr,
  output logic      [blit_pkg::PAT_IDX_W-1:0] pat_index,
  input  wire logic                           pix_valid,
  input  wire logic [blit_pkg::COLOR_W-1:0]   src_pix,
  input  wire logic                           mono_bit,
  input  wire logic [blit_pkg::COLOR_W-1:0]   dst_pix,
  output logic                                out_valid,
  output logic      [blit_pkg::COLOR_W-1:0]   out_pix,
  output logic      [blit_pkg::COLOR_W-1:0]   out_bit_en
);
  import blit_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [PITCH_W-1:0] pitch_reg;
  logic [ROP_W-1:0]   rop_reg;
  logic [COLOR_W-1:0] fg_reg;
  logic [COLOR_W-1:0] bg_reg;
  logic [COLOR_W-1:0] mask_reg;
  logic [CTL_W-1:0]   ctl_reg;
  logic [WORD_W-1:0]  rdata_next;
  logic [IDX_W-1:0]   wr_idx;
  logic               wr_pitch;
  logic               wr_rop;
  logic               wr_fg;
  logic               wr_bg;
  logic               wr_mask;
  logic               wr_ctl;

  assign wr_idx   = reg_wdata[WORD_W-1:IDX_LO];
  assign wr_pitch = reg_wr && (wr_idx == IDX_ROW_PITCH);
  assign wr_rop   = reg_wr && (wr_idx == IDX_RASTER_OP);
  assign wr_fg    = reg_wr && (wr_idx == IDX_FOREGROUND);
  assign wr_bg    = reg_wr && (wr_idx == IDX_BACKGROUND);
  assign wr_mask  = reg_wr && (wr_idx == IDX_WRITE_MASK);
  assign wr_ctl   = reg_wr && (wr_idx == IDX_DP_CONTROL);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pitch_reg <= PITCH_RST;
      rop_reg   <= ROP_RST;
      fg_reg    <= COLOR_RST;
      bg_reg    <= COLOR_RST;
      mask_reg  <= MASK_RST;
      ctl_reg   <= CTL_RST;
    end else begin
      if (wr_pitch) pitch_reg <= reg_wdata[PITCH_W-1:0];
      if (wr_rop)   rop_reg   <= reg_wdata[ROP_LO+ROP_W-1:ROP_LO];
      if (wr_fg)    fg_reg    <= reg_wdata[COLOR_W-1:0];
      if (wr_bg)    bg_reg    <= reg_wdata[COLOR_W-1:0];
      if (wr_mask)  mask_reg  <= reg_wdata[COLOR_W-1:0];
      if (wr_ctl)   ctl_reg   <= reg_wdata[CTL_W-1:0];
    end
  end

  // read mux: reserved bits and unmapped indices read zero
  assign rdata_next =
      !reg_rd                          ? {WORD_W{1'b0}} :
      (reg_addr == IDX_ROW_PITCH)      ? {IDX_ROW_PITCH, pitch_reg} :
      (reg_addr == IDX_RASTER_OP)      ? {IDX_RASTER_OP, rop_reg, BYTE_ZERO} :
      (reg_addr == IDX_FOREGROUND)     ? {IDX_FOREGROUND, NIBBLE_ZERO, fg_reg} :
      (reg_addr == IDX_BACKGROUND)     ? {IDX_BACKGROUND, NIBBLE_ZERO, bg_reg} :
      (reg_addr == IDX_WRITE_MASK)     ? {IDX_WRITE_MASK, NIBBLE_ZERO, mask_reg} :
      (reg_addr == IDX_DP_CONTROL)     ? {IDX_DP_CONTROL, 6'h00, ctl_reg} :
                                         {WORD_W{1'b0}};

  // read data stands for one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= {WORD_W{1'b0}};
    else        reg_rdata <= rdata_next;
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  logic     planar;
  logic     pattern_en;
  logic     src_rect;
  logic     dst_rect;
  src_sel_t src_sel;

  assign planar     = ctl_reg[CTL_PLANAR];
  assign pattern_en = ctl_reg[CTL_PATTERN];
  assign src_rect   = ctl_reg[CTL_SRC_RECT] && !pattern_en;
  assign dst_rect   = ctl_reg[CTL_DST_RECT];
  assign src_sel    = src_sel_t'(ctl_reg[CTL_SRC_LO+1:CTL_SRC_LO]);

  // ---------------------------------------------------------------
  // address stepping
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] src_row_reg;
  logic [ADDR_W-1:0] dst_row_reg;
  logic [ADDR_W-1:0] pitch_ext;
  logic [ADDR_W-1:0] src_row_next;
  logic [ADDR_W-1:0] dst_row_next;
  logic [ADDR_W-1:0] src_lin_next;
  logic [ADDR_W-1:0] dst_lin_next;

  // pitch in position units, no scaling
  assign pitch_ext    = {{(ADDR_W-PITCH_W){1'b0}}, pitch_reg};
  assign src_row_next = ADDR_W'(src_row_reg + pitch_ext);
  assign dst_row_next = ADDR_W'(dst_row_reg + pitch_ext);
  assign src_lin_next = ADDR_W'(src_addr + 1'b1);
  assign dst_lin_next = ADDR_W'(dst_addr + 1'b1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_row_reg <= {ADDR_W{1'b0}};
      dst_row_reg <= {ADDR_W{1'b0}};
      src_addr    <= {ADDR_W{1'b0}};
      dst_addr    <= {ADDR_W{1'b0}};
    end else if (addr_load) begin
      src_row_reg <= src_start;
      dst_row_reg <= dst_start;
      src_addr    <= src_start;
      dst_addr    <= dst_start;
    end else if (next_row) begin
      src_row_reg <= src_rect ? src_row_next : src_lin_next;
      dst_row_reg <= dst_rect ? dst_row_next : dst_lin_next;
      src_addr    <= src_rect ? src_row_next : src_lin_next;
      dst_addr    <= dst_rect ? dst_row_next : dst_lin_next;
    end else if (next_pixel) begin
      src_addr    <= src_lin_next;
      dst_addr    <= dst_lin_next;
    end
  end

  // ---------------------------------------------------------------
  // 8x8 pattern walk
  // ---------------------------------------------------------------
  logic [PAT_AXIS_W-1:0] anchor_x_reg;
  logic [PAT_AXIS_W-1:0] anchor_y_reg;
  logic [PAT_AXIS_W-1:0] col_reg;
  logic [PAT_AXIS_W-1:0] row_reg;
  logic [PAT_AXIS_W-1:0] col_next;
  logic [PAT_AXIS_W-1:0] row_next;

  assign col_next = addr_load ? '0 : next_row ? '0 : next_pixel ? PAT_AXIS_W'(col_reg + 1'b1) : col_reg;
  assign row_next = addr_load ? '0 : next_row ? PAT_AXIS_W'(row_reg + 1'b1) : row_reg;

  // wrap within 8 pixels and 8 rows from anchor
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      anchor_x_reg <= '0;
      anchor_y_reg <= '0;
      col_reg      <= '0;
      row_reg      <= '0;
      pat_index    <= '0;
    end else begin
      if (addr_load) begin
        anchor_x_reg <= pat_anchor[PAT_AXIS_W-1:0];
        anchor_y_reg <= pat_anchor[PAT_IDX_W-1:PAT_AXIS_W];
      end
      col_reg   <= col_next;
      row_reg   <= row_next;
      pat_index <= addr_load ? pat_anchor :
                   {PAT_AXIS_W'(anchor_y_reg + row_next), PAT_AXIS_W'(anchor_x_reg + col_next)};
    end
  end

  // ---------------------------------------------------------------
  // colour source, raster operation and write masks
  // ---------------------------------------------------------------
  logic [COLOR_W-1:0] color_keep;
  logic [COLOR_W-1:0] fg_eff;
  logic [COLOR_W-1:0] bg_eff;
  logic [COLOR_W-1:0] s_bits;
  logic [COLOR_W-1:0] rop_bits;
  logic [COLOR_W-1:0] bit_en;
  logic [COLOR_W-1:0] merged;

  assign color_keep = planar ? {{(COLOR_W-MAP_W){1'b0}}, {MAP_W{1'b1}}} : {COLOR_W{1'b1}};
  assign fg_eff     = fg_reg & color_keep;
  assign bg_eff     = bg_reg & color_keep;

  assign s_bits = (src_sel == SRC_FIXED) ? fg_eff :
                  (src_sel == SRC_MONO)  ? (mono_bit ? fg_eff : bg_eff) :
                                           src_pix;

  // per-bit code lookup, a is msb
  for (genvar gi = 0; gi < COLOR_W; gi++) begin : g_rop
    assign rop_bits[gi] = rop_reg[~{s_bits[gi], dst_pix[gi]}];
  end

  assign bit_en = planar ? {{(COLOR_W-MAP_W){1'b0}}, mask_reg[MAP_W-1:0]} : mask_reg;

  assign merged = (rop_bits & bit_en) | (dst_pix & ~bit_en);

  // one registered result per valid pixel
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid  <= 1'b0;
      out_pix    <= '0;
      out_bit_en <= '0;
    end else begin
      out_valid <= pix_valid;
      if (pix_valid) begin
        out_pix    <= merged;
        out_bit_en <= bit_en;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_pix_in;
    pix_valid;
  endsequence
  sequence s_row_step;
    !addr_load && next_row;
  endsequence
  property p_rop_bit0;
    @(posedge core_clk) disable iff (!rst_n)
    s_pix_in ##1 out_bit_en[0] |->
      out_pix[0] == $past(rop_reg[3 - {s_bits[0], dst_pix[0]}]);
  endproperty
  a_rop_bit0: assert property (p_rop_bit0) else $error("rop result bit 0 wrong");
  property p_keep_disabled;
    @(posedge core_clk) disable iff (!rst_n)
    s_pix_in |=> ((out_pix & ~out_bit_en) == ($past(dst_pix) & ~out_bit_en));
  endproperty
  a_keep_disabled: assert property (p_keep_disabled) else $error("disabled bit changed");
  property p_planar_mask;
    @(posedge core_clk) disable iff (!rst_n)
    (s_pix_in and planar) |=> out_bit_en == {4'h0, $past(mask_reg[3:0])};
  endproperty
  a_planar_mask: assert property (p_planar_mask) else $error("planar map mask wrong");
  property p_fixed_fill;
    @(posedge core_clk) disable iff (!rst_n)
    (s_pix_in and src_sel == SRC_FIXED && rop_reg == 4'h3 && !planar) |=>
      out_pix == (($past(fg_reg) & out_bit_en) | ($past(dst_pix) & ~out_bit_en));
  endproperty
  a_fixed_fill: assert property (p_fixed_fill) else $error("fill colour wrong");
  property p_mono_bg;
    @(posedge core_clk) disable iff (!rst_n)
    (s_pix_in and src_sel == SRC_MONO && !mono_bit && rop_reg == 4'h3 && mask_reg == 8'hFF && !planar) |=>
      out_pix == $past(bg_reg);
  endproperty
  a_mono_bg: assert property (p_mono_bg) else $error("mono zero not background");
  property p_planar_color;
    @(posedge core_clk) disable iff (!rst_n)
    (s_pix_in and planar && src_sel == SRC_FIXED) |-> s_bits[7:4] == 4'h0;
  endproperty
  a_planar_color: assert property (p_planar_color) else $error("upper colour bits used");
  property p_pitch_rect;
    @(posedge core_clk) disable iff (!rst_n)
    (s_row_step and dst_rect) |=> dst_addr == ADDR_W'($past(dst_row_reg) + $past(pitch_ext));
  endproperty
  a_pitch_rect: assert property (p_pitch_rect) else $error("pitch not applied");
  property p_no_pitch;
    @(posedge core_clk) disable iff (!rst_n)
    (s_row_step and !dst_rect) |=> dst_addr == ADDR_W'($past(dst_addr) + 1'b1);
  endproperty
  a_no_pitch: assert property (p_no_pitch) else $error("pitch applied to linear region");
  property p_decode_only;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_wdata[15:12] != IDX_ROW_PITCH) |=> $stable(pitch_reg);
  endproperty
  a_decode_only: assert property (p_decode_only) else $error("pitch written by other index");
  property p_pattern_wrap;
    @(posedge core_clk) disable iff (!rst_n)
    (!addr_load && !next_row && next_pixel) |=> pat_index[2:0] == 3'($past(pat_index[2:0]) + 1'b1);
  endproperty
  a_pattern_wrap: assert property (p_pattern_wrap) else $error("pattern column step wrong");
  // a back-to-back read may refill the word in the cycle after
  property p_reserved_zero;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == IDX_FOREGROUND) |=>
      reg_rdata[15:8] == {IDX_FOREGROUND, 4'h0} ##1 ($past(reg_rd) || reg_rdata == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");
endmodule // blit_rop_mask_datapath

// File: display_memory_model.sv
// display memory model that feeds source and destination pixels to the datapath
`timescale 1ns/1ps
module display_memory_model (
  input  wire logic        pix_valid,
  input  wire logic [19:0] src_addr,
  input  wire logic [19:0] dst_addr,
  output logic      [7:0]  src_pix,
  output logic             mono_bit,
  output logic      [7:0]  dst_pix
);
  logic [7:0] mem [0:255];
  // ---------------------------------------------------------------
  // contents
  // ---------------------------------------------------------------
  // pattern stored linearly
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 59) ^ 8'hA5;
    end
  end
  // ---------------------------------------------------------------
  // read port: lines not qualified by pix_valid show the inverse
  // ---------------------------------------------------------------
  assign src_pix = pix_valid ? mem[src_addr[7:0]] : ~mem[src_addr[7:0]];
  assign dst_pix = pix_valid ? mem[dst_addr[7:0]] : ~mem[dst_addr[7:0]];
  assign mono_bit = pix_valid ? mem[src_addr[7:0]][0] : ~mem[src_addr[7:0]][0];
endmodule // display_memory_model

// File: test_blit_rop_mask_datapath.sv
// self-checking bench for the block-transfer pixel datapath
`timescale 1ns/1ps
module test_blit_rop_mask_datapath;
  import blit_pkg::*;
  logic        core_clk, nrst, reg_wr, reg_rd, addr_load, next_pixel, next_row;
  logic        pix_valid, mono_bit, out_valid;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [19:0] src_start, dst_start, src_addr, dst_addr;
  logic [5:0]  pat_anchor, pat_index;
  logic [7:0]  src_pix, dst_pix, out_pix, out_bit_en;
  int          failures, check_count, seed;
  int          pitch, rop, fg, bg, mask, ctl, sr, sc, dr, dc, prow, pcol, ac;
  int          modes [8] = '{32'h32, 32'h34, 32'h31, 32'h33, 32'h35, 32'h36, 32'h32, 32'h34};
  int          amodes [5] = '{32'h30, 32'h10, 32'h20, 32'h00, 32'h38};

  blit_rop_mask_datapath dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_load(addr_load), .src_start(src_start),
    .dst_start(dst_start), .pat_anchor(pat_anchor), .next_pixel(next_pixel), .next_row(next_row),
    .src_addr(src_addr), .dst_addr(dst_addr), .pat_index(pat_index), .pix_valid(pix_valid),
    .src_pix(src_pix), .mono_bit(mono_bit), .dst_pix(dst_pix), .out_valid(out_valid), .out_pix(out_pix),
    .out_bit_en(out_bit_en));
  display_memory_model mem_model (.pix_valid(pix_valid), .src_addr(src_addr), .dst_addr(dst_addr),
    .src_pix(src_pix), .mono_bit(mono_bit), .dst_pix(dst_pix));

  // clock at 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // register bus master
  // ---------------------------------------------------------------
  task automatic wr(input logic [15:0] w);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read word lands one cycle after the strobe, zero after that
  task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= idx;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(20'(reg_rdata), 20'(exp));
    @(posedge core_clk);
    #1 check(20'(reg_rdata), 20'h0);
  endtask

  // ---------------------------------------------------------------
  // reference model of the pixel result
  // ---------------------------------------------------------------
  function automatic int expect_pix(int s, int m, int d);
    int f, b, sv, en, r;
    f  = ctl[0] ? fg & 15 : fg;
    b  = ctl[0] ? bg & 15 : bg;
    en = ctl[0] ? mask & 15 : mask;
    sv = (ctl[2:1] == 2) ? f : (ctl[2:1] == 1) ? (m ? f : b) : s;
    r  = 0;
    for (int i = 0; i < 8; i++) begin
      r |= ((rop >> (3 - 2 * ((sv >> i) & 1) - ((d >> i) & 1))) & 1) << i;
    end
    return (r & en) | (d & ~en & 255);
  endfunction

  // one pixel through the datapath
  task automatic pix();
    int s, d, m;
    @(posedge core_clk);
    pix_valid <= 1'b1;
    @(posedge core_clk);
    s = src_pix;
    d = dst_pix;
    m = mono_bit;
    pix_valid <= 1'b0;
    #1 check(20'(out_valid), 20'h1);
    check(20'(out_pix), 20'(expect_pix(s, m, d)));
    check(20'(out_bit_en), 20'(ctl[0] ? mask & 15 : mask));
  endtask

  // address step: 0 load, 1 next pixel, 2 next row
  task automatic step(input int kind);
    int a, b, c;
    a = $random(seed) & 255;
    b = $random(seed) & 255;
    c = $random(seed) & 63;
    @(posedge core_clk);
    addr_load  <= (kind == 0);
    next_pixel <= (kind == 1);
    next_row   <= (kind == 2);
    src_start  <= 20'(a);
    dst_start  <= 20'(b);
    pat_anchor <= 6'(c);
    @(posedge core_clk);
    addr_load  <= 1'b0;
    next_pixel <= 1'b0;
    next_row   <= 1'b0;
    if (kind == 0) begin
      sr = a; sc = a; dr = b; dc = b; prow = c >> 3; pcol = c & 7; ac = pcol;
    end else if (kind == 1) begin
      sc++; dc++; pcol = (pcol + 1) % 8;
    end else begin
      sr = (ctl[4] && !ctl[3]) ? sr + pitch : sc + 1;
      dr = ctl[5] ? dr + pitch : dc + 1;
      sc = sr; dc = dr; prow = (prow + 1) % 8; pcol = ac;
    end
    #1 check(dst_addr, 20'(dc));
    if (!ctl[3]) check(src_addr, 20'(sc));
    check(20'(pat_index), 20'(prow * 8 + pcol));
    check(20'(out_valid), 20'h0);
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial begin
    #(100 * 20000);
    failures++;
    $display("watchdog expired");
    summarize();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 46020; failures = 0; check_count = 0; nrst = 1'b0;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000; addr_load = 1'b0;
    next_pixel = 1'b0; next_row = 1'b0; src_start = 20'h00000; dst_start = 20'h00000;
    pat_anchor = 6'h00; pix_valid = 1'b0;
    pitch = 0; rop = 3; fg = 0; bg = 0; mask = 255; ctl = 32'h30;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(4'h8, 16'h8000);
    rd(4'h9, 16'h9300);
    rd(4'hA, 16'hA000);
    rd(4'hB, 16'hB000);
    rd(4'hE, 16'hE0FF);
    rd(4'h0, 16'h0000);
    $display("test reset values done");
    repeat (4) begin
      pitch = $random(seed) & 32'hFF8;
      wr(16'(32'h8000 | pitch));
      rd(4'h8, 16'(32'h8000 | pitch));
      rop = $random(seed) & 15;
      wr(16'(32'h9000 | (rop << 8) | ($random(seed) & 255)));
      rd(4'h9, 16'(32'h9000 | (rop << 8)));
      fg = $random(seed) & 255;
      wr(16'(32'hA000 | ($random(seed) & 32'hF00) | fg));
      rd(4'hA, 16'(32'hA000 | fg));
      bg = $random(seed) & 255;
      wr(16'(32'hB000 | ($random(seed) & 32'hF00) | bg));
      rd(4'hB, 16'(32'hB000 | bg));
      mask = $random(seed) & 255;
      wr(16'(32'hE000 | ($random(seed) & 32'hF00) | mask));
      rd(4'hE, 16'(32'hE000 | mask));
      wr(16'h5FFF);
      rd(4'h8, 16'(32'h8000 | pitch));
    end
    $display("test register access done");
    step(0);
    for (int k = 0; k < 16; k++) begin
      rop = k;
      mask = $random(seed) & 255;
      wr(16'(32'h9000 | (k << 8)));
      wr(16'(32'hE000 | mask));
      repeat (3) begin
        pix();
        step(1);
      end
    end
    $display("test raster codes and masks done");
    for (int k = 0; k < 8; k++) begin
      // last two passes: plain copy with every plane open
      ctl = modes[k]; fg = $random(seed) & 255; bg = $random(seed) & 255;
      mask = (k > 5) ? 255 : $random(seed) & 255;
      rop = (k > 5) ? 3 : $random(seed) & 15;
      wr(16'(32'hF000 | ctl));
      wr(16'(32'hA000 | fg));
      wr(16'(32'hB000 | bg));
      wr(16'(32'hE000 | mask));
      wr(16'(32'h9000 | (rop << 8)));
      repeat (4) begin
        pix();
        step(1);
      end
    end
    $display("test source modes and planar done");
    pitch = 32'h040;
    wr(16'h8040);
    for (int k = 0; k < 5; k++) begin
      ctl = amodes[k];
      wr(16'(32'hF000 | ctl));
      step(0);
      repeat (9) step(1);
      repeat (2) step(2);
      step(1);
    end
    $display("test address stepping and pattern wrap done");
    summarize();
  end
endmodule // test_blit_rop_mask_datapath
